// [rtl/cpu_exception_loop_control.v]
// Functional notes
// - 24-bit address with 3-bit function code gives eight 16 Mbyte spaces.
// - page fault suspends, saves restart pc, later refetches and restarts instruction.
// - loop mode entered by decrement-branch-loop instruction with displacement -4.
// - in loop mode instruction fetches are suppressed, only data cycles run.
// - after each looped data operation check condition, decrement and test count.
// - any exception or interrupt leaves loop mode.
// - only one-word instructions without flow change are loopable.
// - vector table base points at 256 long-word vectors, 1024 bytes.
// - reset vector is two long words: supervisor stack pointer then pc.
// - vector address is vector number times four plus table base.
// - vectors fetched in supervisor data space; reset vector in supervisor program space.
// - external device may supply vector on acknowledge, else core generates it.
// - exception runs four steps: sr copy, vector, save context, load context.
// - frame holds sr, pc, vector offset and format field checked on return.
// - core is always in exactly one of four processing states.
// - second bus error during bus error processing halts the core, or enters background state when background is enabled.
// - breakpoint, background instruction or double fault enter background state.
// - supervisor flag selects privilege and user or supervisor stack pointer.
// - privileged instructions refused at user level.
// - only reset vector location fixed; table base is rewritable.
// - seven basic addressing modes are decoded.
// - indirect supports postincrement, predecrement, displacement; pc-relative supports index, displacement.
`timescale 1ns/100ps
`include "exc_loop_consts.vh"

module cpu_exception_loop_control #(
  parameter AW = `ADDR_W
) (
  input  wire          clk,
  input  wire          rstn,
  // executing instruction
  input  wire          instrDone,
  input  wire          instrIsLoopBranch,
  input  wire [15:0]   branchDisp,
  input  wire          loopCondTrue,
  input  wire [15:0]   loopCountIn,
  input  wire          prevOneWord,
  input  wire          prevNoFlowChange,
  input  wire          loopedDataDone,
  input  wire          instrPrivileged,
  input  wire          instrBgnd,
  input  wire          instrRte,
  input  wire          instrTrap,
  input  wire [7:0]    trapVector,
  input  wire [31:0]   curPc,
  input  wire [31:0]   nextPc,
  input  wire [5:0]    eaField,
  input  wire          vbrWrite,
  input  wire [AW-1:0] vbrWdata,
  input  wire          bgndEnable,
  // exception sources
  input  wire          breakpoint,
  input  wire          pageFault,
  input  wire [2:0]    irqLevel,
  input  wire          iackAutovector,
  // memory bus
  input  wire          memAck,
  input  wire          memBerr,
  input  wire [31:0]   memRdata,
  output reg           memReq_q,
  output reg  [AW-1:0] memAddr_q,
  output reg  [2:0]    memFc_q,
  output reg           memWrite_q,
  output reg  [31:0]   memWdata_q,
  // status to core
  output reg  [1:0]    procState_q,
  output reg  [15:0]   sr_q,
  output reg           stackSelSuper_q,
  output reg  [AW-1:0] vectorTableBase_q,
  output reg           pcLoad_q,
  output reg  [31:0]   pcNew_q,
  output reg           loopMode_q,
  output reg           fetchSuppress_q,
  output reg  [15:0]   loopCount_q,
  output reg           privViolation_q,
  output reg  [2:0]    eaMode_q,
  output reg  [1:0]    eaForm_q,
  output reg           eaIllegal_q
);

  localparam [3:0] ST_RST_SSP = 4'h0;
  localparam [3:0] ST_RST_PC  = 4'h1;
  localparam [3:0] ST_NORMAL  = 4'h2;
  localparam [3:0] ST_EXC_SR  = 4'h3;
  localparam [3:0] ST_EXC_VEC = 4'h4;
  localparam [3:0] ST_PUSH_LO = 4'h5;
  localparam [3:0] ST_PUSH_HI = 4'h6;
  localparam [3:0] ST_EXC_NEW = 4'h7;
  localparam [3:0] ST_RTE_HI  = 4'h8;
  localparam [3:0] ST_RTE_LO  = 4'h9;
  localparam [3:0] ST_HALT    = 4'hA;
  localparam [3:0] ST_BGND    = 4'hB;

  // addressing mode classes
  localparam [2:0] EA_REG_DIRECT  = 3'h0;
  localparam [2:0] EA_REG_IND     = 3'h1;
  localparam [2:0] EA_REG_IND_IDX = 3'h2;
  localparam [2:0] EA_PC_DISP     = 3'h3;
  localparam [2:0] EA_PC_IDX      = 3'h4;
  localparam [2:0] EA_ABSOLUTE    = 3'h5;
  localparam [2:0] EA_IMMEDIATE   = 3'h6;
  localparam [1:0] FORM_PLAIN     = 2'h0;
  localparam [1:0] FORM_POSTINC   = 2'h1;
  localparam [1:0] FORM_PREDEC    = 2'h2;
  localparam [1:0] FORM_DISP      = 2'h3;

  reg [3:0]    state_q;
  reg [15:0]   srCopy_q;
  reg [7:0]    vecNum_q;
  reg          vecExternal_q;
  reg          excIsBusErr_q;
  reg [2:0]    excIrqLevel_q;
  reg          excIsIrq_q;
  reg [31:0]   framePc_q;
  reg [AW-1:0] ssp_q;
  reg [31:0]   popHi_q;

  wire [2:0] srMask    = sr_q[`SR_MASK_HI:`SR_MASK_LO];
  wire       irqTake   = (irqLevel != 3'h0) && ((irqLevel > srMask) || (irqLevel == 3'h7));
  wire       isSuper   = sr_q[`SR_SUPV_BIT];
  wire       privFault = instrDone && instrPrivileged && !isSuper;
  wire [AW-1:0] vecAddr = vectorTableBase_q + {{(AW-10){1'b0}}, vecNum_q, 2'b00};
  wire [15:0]   fmtOfs  = {`FRAME_FMT0, 2'b00, vecNum_q, 2'b00};
  wire          busDone = memReq_q && (memAck || memBerr);

  task startBus;
    input [AW-1:0] addr;
    input [2:0]    fc;
    input          wr;
    input [31:0]   data;
    begin
      memReq_q   <= 1'b1;
      memAddr_q  <= addr;
      memFc_q    <= fc;
      memWrite_q <= wr;
      memWdata_q <= data;
    end
  endtask

  task enterException;
    input [7:0]  num;
    input        external;
    input        busErr;
    input [31:0] pc;
    begin
      state_q       <= ST_EXC_SR;
      vecNum_q      <= num;
      vecExternal_q <= external;
      excIsBusErr_q <= busErr;
      framePc_q     <= pc;
      loopMode_q    <= 1'b0;
    end
  endtask

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q           <= ST_RST_SSP;
      memReq_q          <= 1'b1;
      memAddr_q         <= `VBR_RESET;
      memFc_q           <= `FC_SUPV_PROG;
      memWrite_q        <= 1'b0;
      memWdata_q        <= 32'h00000000;
      sr_q              <= `SR_RESET;
      srCopy_q          <= `SR_RESET;
      vectorTableBase_q <= `VBR_RESET;
      vecNum_q          <= 8'h00;
      vecExternal_q     <= 1'b0;
      excIsBusErr_q     <= 1'b0;
      excIrqLevel_q     <= 3'h0;
      excIsIrq_q        <= 1'b0;
      framePc_q         <= 32'h00000000;
      ssp_q             <= {AW{1'b0}};
      popHi_q           <= 32'h00000000;
      pcLoad_q          <= 1'b0;
      pcNew_q           <= 32'h00000000;
      loopMode_q        <= 1'b0;
      loopCount_q       <= 16'h0000;
      privViolation_q   <= 1'b0;
    end else begin
      pcLoad_q        <= 1'b0;
      privViolation_q <= 1'b0;
      if (busDone)
        memReq_q <= 1'b0;
      case (state_q)
        ST_RST_SSP: begin
          if (busDone) begin
            ssp_q <= memRdata[AW-1:0];
            // reset vector from supervisor program space
            startBus(`VBR_RESET + `VEC_OFS_RESET_PC, `FC_SUPV_PROG, 1'b0, 32'h00000000);
            state_q <= ST_RST_PC;
          end
        end
        ST_RST_PC: begin
          if (busDone) begin
            pcNew_q  <= memRdata;
            pcLoad_q <= 1'b1;
            state_q  <= ST_NORMAL;
          end
        end
        ST_NORMAL: begin
          // table base may be moved by a supervisor write in normal processing
          if (vbrWrite && isSuper)
            vectorTableBase_q <= vbrWdata;
          if (pageFault)
            enterException(`VEC_NUM_BUSERR, 1'b0, 1'b1, curPc);
          else if (bgndEnable && (breakpoint || (instrDone && instrBgnd))) begin
            state_q    <= ST_BGND;
            loopMode_q <= 1'b0;
          end else if (privFault) begin
            privViolation_q <= 1'b1;
            enterException(`VEC_NUM_PRIV, 1'b0, 1'b0, curPc);
          end else if (instrDone && instrTrap)
            enterException(trapVector, 1'b0, 1'b0, nextPc);
          else if (irqTake) begin
            excIsIrq_q    <= 1'b1;
            excIrqLevel_q <= irqLevel;
            enterException(`VEC_NUM_AUTO_BASE + {5'h00, irqLevel}, !iackAutovector, 1'b0, nextPc);
          end else if (instrDone && instrRte && isSuper) begin
            startBus(ssp_q, `FC_SUPV_DATA, 1'b0, 32'h00000000);
            state_q <= ST_RTE_HI;
          end else if (instrDone && instrIsLoopBranch && !loopMode_q) begin
            // looped instruction must be one word, no flow change
            if (branchDisp == `LOOP_DISP && prevOneWord && prevNoFlowChange && !loopCondTrue
                && loopCountIn != 16'h0000) begin
              loopMode_q  <= 1'b1;
              loopCount_q <= loopCountIn - 16'h0001;
            end
          end else if (loopMode_q && loopedDataDone) begin
            // condition then count after each pass
            if (loopCondTrue)
              loopMode_q <= 1'b0;
            else begin
              loopCount_q <= loopCount_q - 16'h0001;
              if (loopCount_q - 16'h0001 == `LOOP_COUNT_END)
                loopMode_q <= 1'b0;
            end
          end
        end
        ST_EXC_SR: begin
          srCopy_q                 <= sr_q;
          sr_q[`SR_SUPV_BIT]       <= 1'b1;
          sr_q[`SR_TRACE_BIT]      <= 1'b0;
          if (excIsIrq_q)
            sr_q[`SR_MASK_HI:`SR_MASK_LO] <= excIrqLevel_q;
          if (vecExternal_q)
            startBus({{(AW-4){1'b1}}, excIrqLevel_q, 1'b1}, `FC_CPU_SPACE, 1'b0, 32'h00000000);
          state_q <= ST_EXC_VEC;
        end
        ST_EXC_VEC: begin
          if (!vecExternal_q || busDone) begin
            if (vecExternal_q)
              vecNum_q <= memBerr ? `VEC_NUM_SPURIOUS : memRdata[7:0];
            excIsIrq_q <= 1'b0;
            state_q    <= ST_PUSH_LO;
          end
        end
        ST_PUSH_LO: begin
          if (!memReq_q && !busDone) begin
            startBus(ssp_q - `LONG_BYTES, `FC_SUPV_DATA, 1'b1, {framePc_q[15:0], fmtOfs});
          end else if (busDone) begin
            if (memBerr && excIsBusErr_q)
              state_q <= bgndEnable ? ST_BGND : ST_HALT;
            else if (memBerr)
              enterException(`VEC_NUM_BUSERR, 1'b0, 1'b1, framePc_q);
            else
              state_q <= ST_PUSH_HI;
          end
        end
        ST_PUSH_HI: begin
          if (!memReq_q && !busDone) begin
            startBus(ssp_q - `FRAME_BYTES, `FC_SUPV_DATA, 1'b1, {srCopy_q, framePc_q[31:16]});
          end else if (busDone) begin
            if (memBerr && excIsBusErr_q)
              state_q <= bgndEnable ? ST_BGND : ST_HALT;
            else if (memBerr)
              enterException(`VEC_NUM_BUSERR, 1'b0, 1'b1, framePc_q);
            else begin
              ssp_q   <= ssp_q - `FRAME_BYTES;
              state_q <= ST_EXC_NEW;
            end
          end
        end
        // step four: fetch handler address and resume
        ST_EXC_NEW: begin
          if (!memReq_q && !busDone) begin
            startBus(vecAddr, `FC_SUPV_DATA, 1'b0, 32'h00000000);
          end else if (busDone) begin
            if (memBerr && excIsBusErr_q)
              state_q <= bgndEnable ? ST_BGND : ST_HALT;
            else if (memBerr)
              enterException(`VEC_NUM_BUSERR, 1'b0, 1'b1, framePc_q);
            else begin
              pcNew_q  <= memRdata;
              pcLoad_q <= 1'b1;
              state_q  <= ST_NORMAL;
            end
          end
        end
        ST_RTE_HI: begin
          if (busDone) begin
            popHi_q <= memRdata;
            if (memBerr)
              enterException(`VEC_NUM_BUSERR, 1'b0, 1'b1, curPc);
            else begin
              startBus(ssp_q + `LONG_BYTES, `FC_SUPV_DATA, 1'b0, 32'h00000000);
              state_q <= ST_RTE_LO;
            end
          end
        end
        ST_RTE_LO: begin
          if (busDone) begin
            if (memBerr)
              enterException(`VEC_NUM_BUSERR, 1'b0, 1'b1, curPc);
            else if (memRdata[15:12] != `FRAME_FMT0)
              enterException(`VEC_NUM_FORMAT, 1'b0, 1'b0, curPc);
            else begin
              // restored pc refetches a faulted instruction, or resumes after a trap or interrupt
              sr_q     <= popHi_q[31:16];
              pcNew_q  <= {popHi_q[15:0], memRdata[31:16]};
              pcLoad_q <= 1'b1;
              ssp_q    <= ssp_q + `FRAME_BYTES;
              state_q  <= ST_NORMAL;
            end
          end
        end
        ST_HALT: begin
          state_q <= ST_HALT;
        end
        ST_BGND: begin
          // dropped enable leaves background
          if (!bgndEnable)
            state_q <= ST_NORMAL;
        end
        default: begin
          state_q <= ST_HALT;
        end
      endcase
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      procState_q     <= `PST_EXCEPTION;
      stackSelSuper_q <= 1'b1;
      fetchSuppress_q <= 1'b0;
    end else begin
      case (state_q)
        ST_NORMAL, ST_RTE_HI, ST_RTE_LO: procState_q <= `PST_NORMAL;
        ST_HALT:                         procState_q <= `PST_HALTED;
        ST_BGND:                         procState_q <= `PST_BACKGROUND;
        default:                         procState_q <= `PST_EXCEPTION;
      endcase
      stackSelSuper_q <= sr_q[`SR_SUPV_BIT];
      fetchSuppress_q <= loopMode_q && (state_q == ST_NORMAL);
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      eaMode_q    <= EA_REG_DIRECT;
      eaForm_q    <= FORM_PLAIN;
      eaIllegal_q <= 1'b0;
    end else begin
      eaForm_q    <= FORM_PLAIN;
      eaIllegal_q <= 1'b0;
      case (eaField[5:3])
        3'h0, 3'h1: eaMode_q <= EA_REG_DIRECT;
        3'h2:       eaMode_q <= EA_REG_IND;
        3'h3:       {eaMode_q, eaForm_q} <= {EA_REG_IND, FORM_POSTINC};
        3'h4:       {eaMode_q, eaForm_q} <= {EA_REG_IND, FORM_PREDEC};
        3'h5:       {eaMode_q, eaForm_q} <= {EA_REG_IND, FORM_DISP};
        3'h6:       eaMode_q <= EA_REG_IND_IDX;
        default: begin
          case (eaField[2:0])
            3'h0, 3'h1: eaMode_q <= EA_ABSOLUTE;
            3'h2:       {eaMode_q, eaForm_q} <= {EA_PC_DISP, FORM_DISP};
            3'h3:       eaMode_q <= EA_PC_IDX;
            3'h4:       eaMode_q <= EA_IMMEDIATE;
            default:    {eaMode_q, eaIllegal_q} <= {EA_REG_DIRECT, 1'b1};
          endcase
        end
      endcase
    end
  end

endmodule // cpu_exception_loop_control

// [rtl/exc_loop_consts.vh]
`ifndef EXC_LOOP_CONSTS_VH
`define EXC_LOOP_CONSTS_VH

// address width for a 16 Mbyte space
`define ADDR_W            24
// function codes: eight address spaces
`define FC_USER_DATA      3'h1
`define FC_USER_PROG      3'h2
`define FC_SUPV_DATA      3'h5
`define FC_SUPV_PROG      3'h6
`define FC_CPU_SPACE      3'h7
// vector table
`define VBR_RESET         24'h000000
`define VEC_OFS_RESET_SSP 24'h000000
`define VEC_OFS_RESET_PC  24'h000004
`define VEC_NUM_BUSERR    8'h02
`define VEC_NUM_FORMAT    8'h0E
`define VEC_NUM_PRIV      8'h08
`define VEC_NUM_SPURIOUS  8'h18
`define VEC_NUM_AUTO_BASE 8'h18
// status register fields
`define SR_RESET          16'h2700
`define SR_TRACE_BIT      15
`define SR_SUPV_BIT       13
`define SR_MASK_HI        10
`define SR_MASK_LO        8
// stack frame
`define FRAME_FMT0        4'h0
`define FRAME_BYTES       24'h000008
`define LONG_BYTES        24'h000004
// loop mode
`define LOOP_DISP         16'hFFFC
`define LOOP_COUNT_END    16'hFFFF
// processing states
`define PST_NORMAL        2'h0
`define PST_EXCEPTION     2'h1
`define PST_HALTED        2'h2
`define PST_BACKGROUND    2'h3

`endif

// [verification/cpu_exception_loop_monitor.sv]
`timescale 1ns/100ps
`include "exc_loop_consts.vh"

module cpu_exception_loop_monitor #(
  parameter AW = `ADDR_W
) (
  input wire          clk,
  input wire          rstn,
  input wire          instrDone,
  input wire          instrIsLoopBranch,
  input wire [15:0]   branchDisp,
  input wire          loopCondTrue,
  input wire [15:0]   loopCountIn,
  input wire          prevOneWord,
  input wire          prevNoFlowChange,
  input wire          loopedDataDone,
  input wire          memAck,
  input wire          memBerr,
  input wire          memReq_q,
  input wire [AW-1:0] memAddr_q,
  input wire [2:0]    memFc_q,
  input wire [1:0]    procState_q,
  input wire [15:0]   sr_q,
  input wire          stackSelSuper_q,
  input wire          loopMode_q,
  input wire          fetchSuppress_q,
  input wire [15:0]   loopCount_q
);
  wire norm = procState_q == `PST_NORMAL;
  wire qual = instrIsLoopBranch && branchDisp == `LOOP_DISP && prevOneWord && prevNoFlowChange;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  a_req_hold: assert property (
    memReq_q && !memAck && !memBerr |=> memReq_q && $stable(memAddr_q) && $stable(memFc_q))
    else $error("request moved early");
  a_req_drop: assert property (
    memReq_q && (memAck || memBerr) |=> !memReq_q || $changed(memAddr_q))
    else $error("request held");
  a_loop_entry: assert property (
    instrDone && qual && !loopCondTrue && loopCountIn != 16'h0000 && norm && !loopMode_q
    |=> loopMode_q && loopCount_q == $past(loopCountIn) - 16'h0001)
    else $error("no loop entry");
  a_loop_qual: assert property (
    instrDone && instrIsLoopBranch && !qual && !loopMode_q |=> !loopMode_q)
    else $error("unfit loop entered");
  a_loop_count: assert property (
    loopMode_q && norm && loopedDataDone && !loopCondTrue
    |=> loopCount_q == $past(loopCount_q) - 16'h0001 && loopMode_q == ($past(loopCount_q) != 16'h0000))
    else $error("loop count wrong");
  a_loop_exit: assert property (
    loopMode_q && norm && loopedDataDone && loopCondTrue |=> !loopMode_q)
    else $error("loop kept on cond");
  a_fetch_supp: assert property (
    $rose(loopMode_q) && norm |=> fetchSuppress_q)
    else $error("fetch not suppressed");
  a_loop_exc: assert property (
    !norm |-> ##[0:2] !loopMode_q)
    else $error("loop kept on exception");
  a_exc_super: assert property (
    $rose(procState_q == `PST_EXCEPTION) |-> ##[0:3] (sr_q[`SR_SUPV_BIT] && !sr_q[`SR_TRACE_BIT]))
    else $error("exception sr wrong");
  a_stack_sel: assert property (
    stackSelSuper_q == $past(sr_q[`SR_SUPV_BIT]))
    else $error("stack select wrong");
endmodule // cpu_exception_loop_monitor

bind cpu_exception_loop_control cpu_exception_loop_monitor #(.AW(AW)) mon_u (
  .clk(clk), .rstn(rstn), .instrDone(instrDone), .instrIsLoopBranch(instrIsLoopBranch),
  .branchDisp(branchDisp), .loopCondTrue(loopCondTrue), .loopCountIn(loopCountIn),
  .prevOneWord(prevOneWord), .prevNoFlowChange(prevNoFlowChange), .loopedDataDone(loopedDataDone),
  .memAck(memAck), .memBerr(memBerr), .memReq_q(memReq_q), .memAddr_q(memAddr_q), .memFc_q(memFc_q),
  .procState_q(procState_q), .sr_q(sr_q), .stackSelSuper_q(stackSelSuper_q), .loopMode_q(loopMode_q),
  .fetchSuppress_q(fetchSuppress_q), .loopCount_q(loopCount_q)
);

// [verification/exc_mem_model.sv]
`timescale 1ns/100ps
`include "exc_loop_consts.vh"

module exc_mem_model #(
  parameter EXT_VEC = 8'h40
) (
  input  wire        clk,
  input  wire        rstn,
  input  wire        req,
  input  wire [23:0] addr,
  input  wire [2:0]  fc,
  input  wire        wr,
  input  wire [31:0] wdata,
  input  wire [1:0]  lat,
  input  wire        berrAll,
  output reg         ack,
  output reg         berr,
  output reg  [31:0] rdata
);
  reg [31:0] mem [int];
  reg [23:0] logA [0:63];
  reg [2:0]  logF [0:63];
  reg [31:0] logD [0:63];
  integer    logN;
  reg [1:0]  cnt;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      {ack, berr, cnt, rdata} <= '0;
      logN = 0;
    end else begin
      ack <= 1'b0;
      berr <= 1'b0;
      // idle data toggles
      rdata <= ~rdata;
      if (req && !ack && !berr) begin
        if (cnt < lat) begin
          cnt <= cnt + 2'h1;
        end else begin
          cnt <= 2'h0;
          {logA[logN], logF[logN], logD[logN]} = {addr, fc, wdata};
          logN = logN + 1;
          ack <= !berrAll;
          berr <= berrAll;
          if (wr) begin
            mem[addr] = wdata;
          end else if (fc == `FC_CPU_SPACE) begin
            rdata <= {24'h000000, EXT_VEC};
          end else begin
            rdata <= mem.exists(addr) ? mem[addr] : {8'h5A, addr};
          end
        end
      end
    end
  end
endmodule // exc_mem_model

// [verification/cpu_exception_loop_control_tb_top.sv]
`timescale 1ns/100ps

module cpu_exception_loop_control_tb_top;
  logic        clk = 1'b0;
  logic        rstn, instrDone, instrIsLoopBranch, loopCondTrue, prevOneWord, prevNoFlowChange, loopedDataDone;
  logic        instrPrivileged, instrBgnd, instrRte, instrTrap, vbrWrite, bgndEnable, breakpoint, pageFault;
  logic        iackAutovector, memAck, memBerr, berrAll, memReq_q, memWrite_q, stackSelSuper_q, pcLoad_q;
  logic        loopMode_q, fetchSuppress_q, privViolation_q, eaIllegal_q;
  logic [15:0] branchDisp, loopCountIn, sr_q, loopCount_q;
  logic [31:0] curPc, nextPc, memRdata, memWdata_q, pcNew_q;
  logic [23:0] vbrWdata, memAddr_q, vectorTableBase_q;
  logic [7:0]  trapVector;
  logic [5:0]  eaField;
  logic [2:0]  irqLevel, memFc_q, eaMode_q;
  logic [1:0]  lat, procState_q, eaForm_q;
  integer      fails = 0, nCompared = 0, cyc = 0, b, i;
  logic [5:0]  eaV [0:4] = '{6'h1A, 6'h22, 6'h2A, 6'h3C, 6'h08};
  logic [4:0]  eaE [0:4] = '{5'h05, 5'h06, 5'h07, 5'h18, 5'h00};

  always #12.5 clk = ~clk;

  cpu_exception_loop_control dut_u (
    .clk(clk), .rstn(rstn), .instrDone(instrDone), .instrIsLoopBranch(instrIsLoopBranch),
    .branchDisp(branchDisp), .loopCondTrue(loopCondTrue), .loopCountIn(loopCountIn), .prevOneWord(prevOneWord),
    .prevNoFlowChange(prevNoFlowChange), .loopedDataDone(loopedDataDone), .instrPrivileged(instrPrivileged),
    .instrBgnd(instrBgnd), .instrRte(instrRte), .instrTrap(instrTrap), .trapVector(trapVector), .curPc(curPc),
    .nextPc(nextPc), .eaField(eaField), .vbrWrite(vbrWrite), .vbrWdata(vbrWdata), .bgndEnable(bgndEnable),
    .breakpoint(breakpoint), .pageFault(pageFault), .irqLevel(irqLevel), .iackAutovector(iackAutovector),
    .memAck(memAck), .memBerr(memBerr), .memRdata(memRdata), .memReq_q(memReq_q), .memAddr_q(memAddr_q),
    .memFc_q(memFc_q), .memWrite_q(memWrite_q), .memWdata_q(memWdata_q), .procState_q(procState_q),
    .sr_q(sr_q), .stackSelSuper_q(stackSelSuper_q), .vectorTableBase_q(vectorTableBase_q), .pcLoad_q(pcLoad_q),
    .pcNew_q(pcNew_q), .loopMode_q(loopMode_q), .fetchSuppress_q(fetchSuppress_q), .loopCount_q(loopCount_q),
    .privViolation_q(privViolation_q), .eaMode_q(eaMode_q), .eaForm_q(eaForm_q), .eaIllegal_q(eaIllegal_q)
  );
  exc_mem_model model_u (
    .clk(clk), .rstn(rstn), .req(memReq_q), .addr(memAddr_q), .fc(memFc_q), .wr(memWrite_q),
    .wdata(memWdata_q), .lat(lat), .berrAll(berrAll), .ack(memAck), .berr(memBerr), .rdata(memRdata)
  );

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    nCompared++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic instr(input logic lb, pv, bg, rt, tr);
    {instrDone, instrIsLoopBranch, instrPrivileged, instrBgnd, instrRte, instrTrap} = {1'b1, lb, pv, bg, rt, tr};
    step(1);
    {instrDone, instrIsLoopBranch, instrPrivileged, instrBgnd, instrRte, instrTrap} = '0;
  endtask
  task automatic wait_st(input logic [1:0] s);
    for (int k = 0; k < 400 && procState_q !== s; k++) step(1);
    check("procState", procState_q, s);
  endtask
  // pc redirect stands one cycle
  task automatic wait_pc(input logic [31:0] pcE);
    for (int k = 0; k < 400 && pcLoad_q !== 1'b1; k++) step(1);
    check("pcLoad", pcLoad_q, 1);
    check("pcNew", pcNew_q, pcE);
    step(2);
  endtask
  task automatic acc(input int j, input logic [23:0] a, input logic [2:0] f);
    check("accAddr", model_u.logA[j], a);
    check("accFc", model_u.logF[j], f);
  endtask
  task automatic ddone;
    loopedDataDone = 1'b1;
    step(1);
    loopedDataDone = 1'b0;
    step(1);
  endtask
  task automatic loopbr(input logic [15:0] d, input logic ow, nf, input logic [15:0] c);
    {branchDisp, prevOneWord, prevNoFlowChange, loopCountIn, loopCondTrue} = {d, ow, nf, c, 1'b0};
    instr(1, 0, 0, 0, 0);
    step(1);
  endtask
  task automatic do_reset;
    rstn = 1'b0;
    step(4);
    check("rstBus", {memReq_q, memFc_q, memAddr_q}, {1'b1, 3'h6, 24'h000000});
    check("rstCore", {procState_q, stackSelSuper_q, sr_q}, {2'h1, 1'b1, 16'h2700});
    check("rstBase", vectorTableBase_q, 0);
    rstn = 1'b1;
    wait_pc(32'h00000400);
  endtask
  task automatic wrap_up;
    if (fails == 0 && nCompared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      wrap_up;
    end
  end

  initial begin
    {rstn, instrDone, instrIsLoopBranch, loopCondTrue, prevOneWord, prevNoFlowChange, loopedDataDone,
     instrPrivileged, instrBgnd, instrRte, instrTrap, vbrWrite, bgndEnable, breakpoint, pageFault,
     iackAutovector, berrAll, branchDisp, loopCountIn, trapVector, curPc, nextPc, eaField, vbrWdata,
     irqLevel, lat} = '0;
    model_u.mem[0] = 32'h00008000;
    model_u.mem[4] = 32'h00000400;
    model_u.mem[24'h001080] = 32'h00002000;
    do_reset;
    acc(0, 24'h000000, 3'h6);
    acc(1, 24'h000004, 3'h6);
    {vbrWrite, vbrWdata} = {1'b1, 24'h001000};
    step(1);
    vbrWrite = 1'b0;
    step(1);
    check("vecBase", vectorTableBase_q, 24'h001000);
    {lat, trapVector, curPc, nextPc} = {2'h3, 8'h20, 32'h00012344, 32'h00012346};
    b = model_u.logN;
    instr(0, 0, 0, 0, 1);
    wait_pc(32'h00002000);
    acc(b, 24'h007FFC, 3'h5);
    check("frameLo", model_u.logD[b], {16'h2346, 4'h0, 12'h080});
    acc(b + 1, 24'h007FF8, 3'h5);
    check("frameHi", model_u.logD[b + 1], {16'h2700, 16'h0001});
    acc(b + 2, 24'h001080, 3'h5);
    model_u.mem[24'h007FF8] = 32'h00000001;
    b = model_u.logN;
    instr(0, 0, 0, 1, 0);
    wait_pc(32'h00012346);
    acc(b, 24'h007FF8, 3'h5);
    check("userMode", {sr_q[13], stackSelSuper_q}, 2'h0);
    b = model_u.logN;
    instr(0, 1, 0, 0, 0);
    wait_pc({8'h5A, 24'h001020});
    acc(b, 24'h007FFC, 3'h5);
    acc(b + 2, 24'h001020, 3'h5);
    for (i = 0; i < 3; i++) begin
      loopbr(i == 0 ? 16'hFFFA : 16'hFFFC, i != 1, i != 2, 16'h0005);
      check("noLoop", loopMode_q, 0);
    end
    loopbr(16'hFFFC, 1, 1, 16'h0002);
    check("loopIn", {fetchSuppress_q, loopMode_q, loopCount_q}, {2'h3, 16'h0001});
    for (i = 0; i < 2; i++) begin
      ddone;
      check("loopCnt", {loopMode_q, loopCount_q}, i ? {1'b0, 16'hFFFF} : {1'b1, 16'h0000});
    end
    loopbr(16'hFFFC, 1, 1, 16'h0009);
    loopCondTrue = 1'b1;
    ddone;
    check("loopCond", loopMode_q, 0);
    loopbr(16'hFFFC, 1, 1, 16'h0009);
    {irqLevel, iackAutovector} = {3'h7, 1'b1};
    wait_st(1);
    irqLevel = 3'h0;
    wait_pc({8'h5A, 24'h00107C});
    check("loopExc", loopMode_q, 0);
    acc(model_u.logN - 1, 24'h00107C, 3'h5);
    {irqLevel, iackAutovector} = {3'h7, 1'b0};
    b = model_u.logN;
    wait_st(1);
    irqLevel = 3'h0;
    wait_pc({8'h5A, 24'h001100});
    check("iackFc", model_u.logF[b], 3'h7);
    acc(model_u.logN - 1, 24'h001100, 3'h5);
    {curPc, pageFault} = {32'h00055552, 1'b1};
    b = model_u.logN;
    step(1);
    pageFault = 1'b0;
    wait_pc({8'h5A, 24'h001008});
    check("restartPc", model_u.logD[b], {16'h5552, 4'h0, 12'h008});
    for (i = 0; i < 5; i++) begin
      eaField = eaV[i];
      step(2);
      check("eaDecode", {eaIllegal_q, eaMode_q, eaForm_q}, {1'b0, eaE[i]});
    end
    berrAll = 1'b1;
    instr(0, 0, 0, 0, 1);
    wait_st(2);
    berrAll = 1'b0;
    do_reset;
    for (i = 0; i < 3; i++) begin
      {bgndEnable, berrAll} = {1'b1, i == 2};
      if (i == 0) begin
        breakpoint = 1'b1;
        step(1);
        breakpoint = 1'b0;
      end else begin
        instr(0, 0, i == 1, 0, i == 2);
      end
      wait_st(3);
      {bgndEnable, berrAll} = 2'h0;
      wait_st(0);
    end
    wrap_up;
  end
endmodule // cpu_exception_loop_control_tb_top
